/* File: core/mic_defines.vh */
// register map, field positions, vectors and reset values of the interrupt controller
`ifndef MIC_DEFINES_VH
`define MIC_DEFINES_VH

`define MIC_ADDR_CTRL0 8'h0B
`define MIC_ADDR_CTRL1 8'h1E
`define MIC_ADDR_SHARED 8'h1B

`define MIC_C0_GIE 0
`define MIC_C0_EXT0_EN 1
`define MIC_C0_EXT1_EN 2
`define MIC_C0_CMP0_EN 3
`define MIC_C0_EXT0_PND 4
`define MIC_C0_EXT1_PND 5
`define MIC_C0_CMP0_PND 6
`define MIC_C0_TEST 7

`define MIC_C1_CMP1_EN 0
`define MIC_C1_EXT2_EN 1
`define MIC_C1_SHR_EN 2
`define MIC_C1_CMP1_PND 4
`define MIC_C1_EXT2_PND 5
`define MIC_C1_SHR_PND 6

`define MIC_SH_T0_EN 0
`define MIC_SH_T1_EN 1
`define MIC_SH_ADC_EN 2
`define MIC_SH_T0_PND 4
`define MIC_SH_T1_PND 5
`define MIC_SH_ADC_PND 6

`define MIC_CTRL0_RST 8'h00
`define MIC_CTRL1_RST 8'h00
`define MIC_SHARED_RST 8'h00

`define MIC_VEC_EXT0 12'h004
`define MIC_VEC_EXT1 12'h008
`define MIC_VEC_CMP0 12'h00C
`define MIC_VEC_CMP1 12'h010
`define MIC_VEC_EXT2 12'h014
`define MIC_VEC_SHR 12'h018

`endif

/* File: core/mic_intc.v */
// interrupt controller: edge capture, enables, priority and vectoring
`timescale 1ns/1ps
`default_nettype none
`include "mic_defines.vh"

// Function
// - vectoring clears global enable
// - requests still latch while globally disabled
// - software re-enable allows nested vectoring
// - no acknowledge while return stack full
// - any pending enabled source wakes device
// - only PC pushed, then branch to vector
// - falling edge on ext pins sets pending
// - ext0/ext1 vector to 04H/08H
// - ext vectoring clears its pending flag
// - comparator falling edge sets comparator pending
// - comparator vectors 0CH/10H, clears its flag
// - timer/adc events set own sub-flags
// - shared source vectors 018H, clears its flag
// - sub-flags cleared only by software
// - control register 0 bit layout
// - control register 1 layout, bits 3,7 zero
// - shared control layout, bits 3,7 zero
// - fixed priority ext0 down to shared
// - interrupt return sets global enable, return not
module mic_intc (
    input wire clk_i,
    input wire rst_n_i,
    input wire clk_en_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire ext_irq_pin_0_i,
    input wire ext_irq_pin_1_i,
    input wire ext_irq_pin_2_i,
    input wire cmp0_out_i,
    input wire cmp1_out_i,
    input wire timer0_ovf_i,
    input wire timer1_ovf_i,
    input wire adc_done_i,
    input wire stack_full_i,
    input wire irq_accept_i,
    input wire return_from_interrupt_i,
    output wire irq_req_o,
    output reg [11:0] vector_o,
    output wire push_pc_o,
    output wire wake_o
);

    // two-stage synchronisers for the five asynchronous lines
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    reg [4:0] prev_q;
    wire [4:0] fall;

    reg global_irq_enable_q;
    reg ext0_enable_q;
    reg ext1_enable_q;
    reg cmp0_enable_q;
    reg test_bit_q;
    reg ext0_pending_q;
    reg ext1_pending_q;
    reg cmp0_pending_q;
    reg cmp1_enable_q;
    reg ext2_enable_q;
    reg shared_irq_enable_q;
    reg cmp1_pending_q;
    reg ext2_pending_q;
    reg shared_irq_pending_q;
    reg timer0_enable_q;
    reg timer1_enable_q;
    reg adc_irq_enable_q;
    reg timer0_pending_q;
    reg timer1_pending_q;
    reg adc_done_pending_q;

    wire [7:0] ctrl0;
    wire [7:0] ctrl1;
    wire [7:0] shared_ctrl;
    wire wr_c0;
    wire wr_c1;
    wire wr_sh;
    wire rd_c0;
    wire rd_c1;
    wire rd_sh;
    wire [5:0] ready;
    wire [5:0] grant;
    wire any_ready;
    wire take;
    wire sub_rise;

    // one register decode shared by the write and read paths
    function addr_hit;
        input strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = strobe && (addr == target);
        end
    endfunction

    function [5:0] pick_first;
        input [5:0] req;
        begin
            pick_first = req & ~(req - 6'h01);
        end
    endfunction

    assign fall = prev_q & ~sync2_q;

    assign ctrl0 = {test_bit_q, cmp0_pending_q, ext1_pending_q, ext0_pending_q,
                    cmp0_enable_q, ext1_enable_q, ext0_enable_q, global_irq_enable_q};
    assign ctrl1 = {1'b0, shared_irq_pending_q, ext2_pending_q, cmp1_pending_q,
                    1'b0, shared_irq_enable_q, ext2_enable_q, cmp1_enable_q};
    assign shared_ctrl = {1'b0, adc_done_pending_q, timer1_pending_q, timer0_pending_q,
                          1'b0, adc_irq_enable_q, timer1_enable_q, timer0_enable_q};

    assign wr_c0 = addr_hit(wr_i, addr_i, `MIC_ADDR_CTRL0);
    assign wr_c1 = addr_hit(wr_i, addr_i, `MIC_ADDR_CTRL1);
    assign wr_sh = addr_hit(wr_i, addr_i, `MIC_ADDR_SHARED);
    assign rd_c0 = addr_hit(rd_i, addr_i, `MIC_ADDR_CTRL0);
    assign rd_c1 = addr_hit(rd_i, addr_i, `MIC_ADDR_CTRL1);
    assign rd_sh = addr_hit(rd_i, addr_i, `MIC_ADDR_SHARED);

    // bit 0 is highest priority
    assign ready = {shared_irq_enable_q & shared_irq_pending_q,
                    ext2_enable_q & ext2_pending_q,
                    cmp1_enable_q & cmp1_pending_q,
                    cmp0_enable_q & cmp0_pending_q,
                    ext1_enable_q & ext1_pending_q,
                    ext0_enable_q & ext0_pending_q};
    assign grant = pick_first(ready);
    assign any_ready = |ready;
    assign irq_req_o = global_irq_enable_q && any_ready && !stack_full_i;
    assign take = irq_req_o && irq_accept_i && clk_en_i;
    // core pushes only the pc on accept; no other state is saved here
    assign push_pc_o = take;
    // combinational so it works with the system clock stopped
    assign wake_o = any_ready;

    assign sub_rise = (timer0_ovf_i & timer0_enable_q) | (timer1_ovf_i & timer1_enable_q)
                      | (adc_done_i & adc_irq_enable_q);

    always @* begin
        case (grant)
            6'h01: vector_o = `MIC_VEC_EXT0;
            6'h02: vector_o = `MIC_VEC_EXT1;
            6'h04: vector_o = `MIC_VEC_CMP0;
            6'h08: vector_o = `MIC_VEC_CMP1;
            6'h10: vector_o = `MIC_VEC_EXT2;
            6'h20: vector_o = `MIC_VEC_SHR;
            default: vector_o = 12'h000;
        endcase
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
            prev_q <= 5'h1F;
        end else if (clk_en_i) begin
            sync1_q <= {cmp1_out_i, cmp0_out_i, ext_irq_pin_2_i, ext_irq_pin_1_i,
                        ext_irq_pin_0_i};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            if (rd_c0) begin
                rdata_o <= ctrl0;
            end else if (rd_c1) begin
                rdata_o <= ctrl1;
            end else if (rd_sh) begin
                rdata_o <= shared_ctrl;
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end

    // control register 0; hardware set beats software clear
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            global_irq_enable_q <= 1'b0;
            ext0_enable_q <= 1'b0;
            ext1_enable_q <= 1'b0;
            cmp0_enable_q <= 1'b0;
            test_bit_q <= 1'b0;
            ext0_pending_q <= 1'b0;
            ext1_pending_q <= 1'b0;
            cmp0_pending_q <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_c0) begin
                global_irq_enable_q <= wdata_i[`MIC_C0_GIE];
                ext0_enable_q <= wdata_i[`MIC_C0_EXT0_EN];
                ext1_enable_q <= wdata_i[`MIC_C0_EXT1_EN];
                cmp0_enable_q <= wdata_i[`MIC_C0_CMP0_EN];
                // stored only; software keeps it at zero
                test_bit_q <= wdata_i[`MIC_C0_TEST];
                ext0_pending_q <= wdata_i[`MIC_C0_EXT0_PND];
                ext1_pending_q <= wdata_i[`MIC_C0_EXT1_PND];
                cmp0_pending_q <= wdata_i[`MIC_C0_CMP0_PND];
            end
            if (take) begin
                global_irq_enable_q <= 1'b0;
            end else if (return_from_interrupt_i) begin
                global_irq_enable_q <= 1'b1;
            end
            if (take && grant[0]) begin
                ext0_pending_q <= 1'b0;
            end
            if (take && grant[1]) begin
                ext1_pending_q <= 1'b0;
            end
            if (take && grant[2]) begin
                cmp0_pending_q <= 1'b0;
            end
            // latched regardless of global enable
            if (fall[0]) begin
                ext0_pending_q <= 1'b1;
            end
            if (fall[1]) begin
                ext1_pending_q <= 1'b1;
            end
            if (fall[3]) begin
                cmp0_pending_q <= 1'b1;
            end
        end
    end

    // control register 1
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp1_enable_q <= 1'b0;
            ext2_enable_q <= 1'b0;
            shared_irq_enable_q <= 1'b0;
            cmp1_pending_q <= 1'b0;
            ext2_pending_q <= 1'b0;
            shared_irq_pending_q <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_c1) begin
                cmp1_enable_q <= wdata_i[`MIC_C1_CMP1_EN];
                ext2_enable_q <= wdata_i[`MIC_C1_EXT2_EN];
                shared_irq_enable_q <= wdata_i[`MIC_C1_SHR_EN];
                cmp1_pending_q <= wdata_i[`MIC_C1_CMP1_PND];
                ext2_pending_q <= wdata_i[`MIC_C1_EXT2_PND];
                shared_irq_pending_q <= wdata_i[`MIC_C1_SHR_PND];
            end
            if (take && grant[3]) begin
                cmp1_pending_q <= 1'b0;
            end
            if (take && grant[4]) begin
                ext2_pending_q <= 1'b0;
            end
            if (take && grant[5]) begin
                shared_irq_pending_q <= 1'b0;
            end
            if (fall[4]) begin
                cmp1_pending_q <= 1'b1;
            end
            if (fall[2]) begin
                ext2_pending_q <= 1'b1;
            end
            if (sub_rise) begin
                shared_irq_pending_q <= 1'b1;
            end
        end
    end

    // shared source control; sub-flags never auto-clear on read or service
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer0_enable_q <= 1'b0;
            timer1_enable_q <= 1'b0;
            adc_irq_enable_q <= 1'b0;
            timer0_pending_q <= 1'b0;
            timer1_pending_q <= 1'b0;
            adc_done_pending_q <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_sh) begin
                timer0_enable_q <= wdata_i[`MIC_SH_T0_EN];
                timer1_enable_q <= wdata_i[`MIC_SH_T1_EN];
                adc_irq_enable_q <= wdata_i[`MIC_SH_ADC_EN];
                timer0_pending_q <= wdata_i[`MIC_SH_T0_PND];
                timer1_pending_q <= wdata_i[`MIC_SH_T1_PND];
                adc_done_pending_q <= wdata_i[`MIC_SH_ADC_PND];
            end
            if (timer0_ovf_i) begin
                timer0_pending_q <= 1'b1;
            end
            if (timer1_ovf_i) begin
                timer1_pending_q <= 1'b1;
            end
            if (adc_done_i) begin
                adc_done_pending_q <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

/* File: testbench/mic_intc_assertions.sv */
// port-level checker of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_intc_assertions (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] rdata_o,
    input wire logic stack_full_i,
    input wire logic irq_accept_i,
    input wire logic return_from_interrupt_i,
    input wire logic irq_req_o,
    input wire logic [11:0] vector_o,
    input wire logic push_pc_o,
    input wire logic wake_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_take_clr_gie: assert property (push_pc_o |=> !irq_req_o)
        else $error("request still up after a take");
    a_full_blocks: assert property (stack_full_i |-> !irq_req_o)
        else $error("request while stack full");
    a_push_only_take: assert property (push_pc_o == (irq_req_o && irq_accept_i && clk_en_i))
        else $error("push without a take");
    a_vec_legal: assert property (irq_req_o |-> vector_o inside {12'h004, 12'h008, 12'h00C,
        12'h010, 12'h014, 12'h018})
        else $error("request with odd vector");
    a_req_wakes: assert property (irq_req_o |-> wake_o)
        else $error("request without wake");
    a_idle_quiet: assert property (!wake_o |-> vector_o == 12'h000 && !irq_req_o)
        else $error("vector without pending source");
    a_rd_idle: assert property ($past(clk_en_i) && !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_rfi_rearms: assert property (return_from_interrupt_i && clk_en_i && !push_pc_o && !wr_i
        && wake_o |=> irq_req_o || stack_full_i)
        else $error("return did not re-arm");
    cover property (push_pc_o && vector_o == 12'h018);
    cover property (stack_full_i && wake_o);
    cover property (return_from_interrupt_i && wake_o);
endmodule
bind mic_intc mic_intc_assertions u_chk (.clk_i, .rst_n_i, .clk_en_i, .rd_i, .wr_i, .rdata_o,
    .stack_full_i, .irq_accept_i, .return_from_interrupt_i, .irq_req_o, .vector_o, .push_pc_o,
    .wake_o);
`default_nettype wire

/* File: testbench/mic_core_model.sv */
// behavioural core: takes vectors, tracks stack depth, returns after a short service
`timescale 1ns/1ps
`default_nettype none
module mic_core_model #(
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic irq_req_i,
    input wire logic pause_i,
    input wire logic slow_i,
    output logic irq_accept_o = 1'b0,
    output logic stack_full_o,
    output logic rfi_o = 1'b0
);
    int depth = 0;
    logic [2:0] svc = 3'h0;
    logic [1:0] cnt = 2'h0;
    assign stack_full_o = depth >= DEPTH;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            depth <= 0;
            svc <= 3'h0;
            irq_accept_o <= 1'b0;
            rfi_o <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
            rfi_o <= 1'b0;
            // slow mode answers only one cycle in four
            irq_accept_o <= irq_req_i & ~irq_accept_o & (~slow_i | (cnt == 2'h3));
            if (irq_accept_o & irq_req_i) begin
                depth <= depth + 1;
                svc <= 3'h4;
            end else if (depth != 0 && !pause_i) begin
                if (svc != 3'h0) begin
                    svc <= svc - 3'h1;
                end else begin
                    rfi_o <= 1'b1;
                    depth <= depth - 1;
                    svc <= 3'h4;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/mic_intc_bench.sv */
// randomised and directed bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_intc_bench;
    logic clk_i = 0, rst_n_i = 0, wr = 0, rd = 0, pause = 0, slow = 0, acc, full, rfi;
    logic [7:0] addr = 0, wdata = 0, r = 8'h51, rdata;
    logic [2:0] pin = 3'h7, ev = 0;
    logic [1:0] cmp = 2'h3;
    logic [11:0] vec, vq[$];
    logic [11:0] pv[6] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
    logic req, push, wake;
    int fail_count = 0, comparisons = 0;
    always #20 clk_i = ~clk_i;
    mic_intc dut (.clk_i, .rst_n_i, .clk_en_i(1'b1), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_irq_pin_0_i(pin[0]),
        .ext_irq_pin_1_i(pin[1]), .ext_irq_pin_2_i(pin[2]), .cmp0_out_i(cmp[0]),
        .cmp1_out_i(cmp[1]), .timer0_ovf_i(ev[0]), .timer1_ovf_i(ev[1]), .adc_done_i(ev[2]),
        .stack_full_i(full), .irq_accept_i(acc), .return_from_interrupt_i(rfi),
        .irq_req_o(req), .vector_o(vec), .push_pc_o(push), .wake_o(wake));
    mic_core_model core (.clk_i, .rst_n_i, .irq_req_i(req), .pause_i(pause), .slow_i(slow),
        .irq_accept_o(acc), .stack_full_o(full), .rfi_o(rfi));
    always @(posedge clk_i) if (push === 1'b1) vq.push_back(vec);
    function automatic [7:0] nx(input [7:0] s);
        nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input [11:0] got, input [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input [7:0] a, input [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input [7:0] a, input [7:0] e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 chk({4'h0, rdata}, {4'h0, e});
    endtask
    // pins and comparators fall, event pulses last one cycle
    task automatic fall(input [2:0] p, input [1:0] c, input [2:0] e);
        @(posedge clk_i);
        pin <= pin & ~p;
        cmp <= cmp & ~c;
        ev <= e;
        @(posedge clk_i);
        ev <= 3'h0;
        repeat (6) @(posedge clk_i);
        #1;
    endtask
    task finish_test;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #80000;
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rreg(8'h0B, 8'h00);
        rreg(8'h55, 8'h00);
        wreg(8'h1E, 8'hFF);
        rreg(8'h1E, 8'h77);
        wreg(8'h1B, 8'hFF);
        rreg(8'h1B, 8'h77);
        wreg(8'h1E, 8'h00);
        repeat (8) begin
            r = nx(r);
            slow <= r[7];
            wreg(8'h1B, {5'h0, r[2:0]});
            fall(3'h0, 2'h0, r[6:4]);
            rreg(8'h1B, {1'b0, r[6:4], 1'b0, r[2:0]});
            rreg(8'h1E, {1'b0, |(r[6:4] & r[2:0]), 6'h0});
            wreg(8'h1B, 8'h00);
            wreg(8'h1E, 8'h00);
        end
        wreg(8'h1B, 8'h01);
        wreg(8'h1E, 8'h07);
        wreg(8'h0B, 8'h0E);
        fall(3'h7, 2'h3, 3'h1);
        chk({11'h0, req}, 12'h000);
        chk({11'h0, wake}, 12'h001);
        rreg(8'h0B, 8'h7E);
        rreg(8'h1E, 8'h77);
        vq = {};
        slow <= 1'b1;
        // pending bits written back as one so the latched requests survive
        wreg(8'h0B, 8'h7F);
        repeat (120) @(posedge clk_i);
        chk(12'(vq.size()), 12'h006);
        foreach (pv[i]) chk(vq.size() > i ? vq[i] : 12'hFFF, pv[i]);
        rreg(8'h0B, 8'h0F);
        rreg(8'h1E, 8'h07);
        rreg(8'h1B, 8'h11);
        pin <= 3'h7;
        cmp <= 2'h3;
        wreg(8'h1E, 8'h00);
        pause <= 1'b1;
        vq = {};
        for (int i = 0; i < 3; i++) begin
            wreg(8'h0B, 8'h03);
            fall(3'h1, 2'h0, 3'h0);
            rreg(8'h0B, i < 2 ? 8'h02 : 8'h13);
            pin <= 3'h7;
        end
        chk(12'(vq.size()), 12'h002);
        pause <= 1'b0;
        repeat (60) @(posedge clk_i);
        chk(12'(vq.size()), 12'h003);
        finish_test();
    end
endmodule
`default_nettype wire
